// ===== hdl/ibsc_pkg.sv
/*
  Package of the two-wire bus sequence control block: register map,
  field layouts, reset values, timing counts, states and carriers.
  Assumes a 100 MHz system clock.
*/
package ibsc_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses on the register bus)
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_SEQ_CTL = 4'h0;
  localparam logic [3:0] ADDR_MODE    = 4'h4;
  localparam logic [3:0] ADDR_STATUS  = 4'h8;

  // Mode register fields
  localparam int BIT_MASTER  = 0;
  localparam int BIT_RELEASE = 1;

  // Status register fields
  localparam int BIT_BUSY    = 0;
  localparam int BIT_STRETCH = 1;
  localparam int RX_LSB      = 8;

  // Reset values
  localparam logic [7:0] SEQ_CTL_RESET = 8'h00;
  localparam logic       MASTER_RESET  = 1'b0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_NS      = 10;
  localparam int QUARTER_NS  = 2500;
  // Least time per bus phase, rounded up to whole cycles
  localparam int QUARTER_CYC = (QUARTER_NS + CLK_NS - 1) / CLK_NS;
  localparam int BYTE_BITS   = 8;
  localparam int STRETCH_AT  = 9;

  // ----------------------------------------------------------------
  // States, operations and carriers
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    IBSC_IDLE = 3'b000,
    IBSC_PH_A = 3'b001,
    IBSC_PH_B = 3'b011,
    IBSC_PH_C = 3'b010,
    IBSC_PH_D = 3'b110
  } ibsc_state_t;

  typedef enum logic [2:0] {
    OP_NONE    = 3'h0,
    OP_START   = 3'h1,
    OP_RESTART = 3'h2,
    OP_STOP    = 3'h3,
    OP_ACK     = 3'h4,
    OP_RECV    = 3'h5
  } ibsc_op_t;

  typedef struct packed {
    logic general_call_irq_enable;
    logic received_ack_status;
    logic ack_value_to_send;
    logic ack_sequence_go;
    logic master_receive_go;
    logic stop_go;
    logic restart_go;
    logic start_go_or_stretch_enable;
  } ibsc_ctl_t;

  typedef struct packed {
    logic sda_low;
    logic scl_low;
  } ibsc_drive_t;

endpackage

// ===== hdl/ibsc_sync3.sv
/*
  Three-stage input synchroniser with agreement filter.
  Assumes an asynchronous level input and one system clock.
*/
`timescale 1ns/1ps
`default_nettype none

module ibsc_sync3 #(
  parameter logic RESET_VAL = 1'b1
) (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_reset,
  // Asynchronous level in, filtered level out
  input  wire logic i_async,
  output var  logic o_level
);

  logic [2:0] sh_r;
  logic [2:0] sh_nxt;
  logic       level_r;
  logic       level_nxt;

  // ----------------------------------------------------------------
  // Shift chain; level moves only when stages two and three agree
  // ----------------------------------------------------------------
  always_comb begin
    sh_nxt    = {sh_r[1:0], i_async};
    level_nxt = (sh_r[1] == sh_r[2]) ? sh_r[2] : level_r;
  end

  // Registers
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      sh_r    <= {3{RESET_VAL}};
      level_r <= RESET_VAL;
    end else begin
      sh_r    <= sh_nxt;
      level_r <= level_nxt;
    end
  end

  assign o_level = level_r;

endmodule

`default_nettype wire

// ===== hdl/ibsc_seq_ctl.sv
/*
  Two-wire bus sequence control: master Start, Repeated Start, Stop,
  Acknowledge and byte receive sequences, slave clock stretching, and
  an Avalon-MM register slave with waitrequest.
  Assumes open-drain lines resolved outside; pin inputs are async.
*/
// Decided for this implementation: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

// Function
// - Acknowledge sequence drives chosen acknowledge value
// - Stop go bit makes Stop, self-clears
// - Restart go bit makes Repeated Start, self-clears
// - Start go bit 0 makes Start, self-clears
// - Slave mode: bit 0 enables clock stretching
module ibsc_seq_ctl
  import ibsc_pkg::*;
#(
  parameter int PHASE_CYC = QUARTER_CYC
) (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  // Avalon-MM slave
  input  wire logic [3:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output var  logic [31:0] o_avs_readdata,
  output var  logic        o_avs_waitrequest,
  // Two-wire bus lines
  input  wire logic        i_scl,
  input  wire logic        i_sda,
  output var  logic        o_scl_o,
  output var  logic        o_scl_oe,
  output var  logic        o_sda_o,
  output var  logic        o_sda_oe
);

  ibsc_ctl_t   ctl_r, ctl_nxt, wctl;
  ibsc_state_t state_r, state_nxt;
  ibsc_op_t    op_r, op_nxt, op_req;
  ibsc_drive_t drive_r, drive_nxt;
  logic [15:0] div_r, div_nxt;
  logic [2:0]  bit_r, bit_nxt;
  logic [7:0]  rx_r, rx_nxt;
  logic        ack_lat_r, ack_lat_nxt;
  logic        master_r, master_nxt;
  logic        ans_r, ans_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic        stretch_r, stretch_nxt;
  logic [3:0]  edges_r, edges_nxt;
  logic        scl_d_r, scl_d_nxt, sda_d_r, sda_d_nxt;
  logic        scl_q, sda_q, busy, tick, fire, seq_wr, release_wr;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  ibsc_sync3 #(.RESET_VAL(1'b1)) u_sync_scl (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_async (i_scl),
    .o_level (scl_q)
  );

  ibsc_sync3 #(.RESET_VAL(1'b1)) u_sync_sda (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_async (i_sda),
    .o_level (sda_q)
  );

  // Line levels per phase A..D, bits [3:0] = D C B A
  function automatic ibsc_drive_t phase_drive(ibsc_op_t op,
                                              ibsc_state_t st,
                                              logic nack);
    logic [3:0]  sda_v;
    logic [3:0]  scl_v;
    logic [1:0]  idx;
    ibsc_drive_t d;
    sda_v = 4'h0;
    scl_v = 4'hf;
    unique case (st)
      IBSC_PH_B: idx = 2'h1;
      IBSC_PH_C: idx = 2'h2;
      IBSC_PH_D: idx = 2'h3;
      default:   idx = 2'h0;
    endcase
    unique case (op)
      OP_START:   begin sda_v = 4'he; scl_v = 4'h8; end
      OP_RESTART: begin sda_v = 4'hc; scl_v = 4'h9; end
      OP_STOP:    begin sda_v = 4'h3; scl_v = 4'h1; end
      OP_ACK:     begin sda_v = {1'b0, {3{~nack}}}; scl_v = 4'hd; end
      OP_RECV:    begin sda_v = 4'h0; scl_v = 4'hd; end
      default:    begin sda_v = 4'h0; scl_v = 4'hf; end
    endcase
    d.sda_low = sda_v[idx];
    d.scl_low = scl_v[idx];
    return d;
  endfunction

  // ----------------------------------------------------------------
  // Bus slave: one wait cycle, then answer
  // ----------------------------------------------------------------
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ans_r;
  assign fire       = i_avs_write & ans_r;
  assign seq_wr     = fire & i_avs_byteenable[0]
                    & (i_avs_address == ADDR_SEQ_CTL);
  assign release_wr = fire & i_avs_byteenable[0]
                    & (i_avs_address == ADDR_MODE)
                    & i_avs_writedata[BIT_RELEASE];
  assign wctl       = ibsc_ctl_t'(i_avs_writedata[7:0]);

  // Answer flag and read data capture
  always_comb begin
    ans_nxt   = (i_avs_read | i_avs_write) & ~ans_r;
    rdata_nxt = rdata_r;
    if (i_avs_read && !ans_r) begin
      unique case (i_avs_address)
        ADDR_SEQ_CTL: rdata_nxt = {24'h0, ctl_r};
        ADDR_MODE:    rdata_nxt = {31'h0, master_r};
        ADDR_STATUS: begin
          rdata_nxt              = 32'h0;
          rdata_nxt[BIT_BUSY]    = busy;
          rdata_nxt[BIT_STRETCH] = stretch_r;
          rdata_nxt[RX_LSB +: 8] = rx_r;
        end
        default:      rdata_nxt = 32'h0;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ans_r   <= 1'b0;
      rdata_r <= 32'h0;
    end else begin
      ans_r   <= ans_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign o_avs_readdata = rdata_r;

  // ----------------------------------------------------------------
  // Master sequencer and control register
  // ----------------------------------------------------------------
  assign busy = (state_r != IBSC_IDLE);
  assign tick = busy && (div_r == 16'(PHASE_CYC - 1));

  // Highest priority go bit wins when several are written
  always_comb begin
    if (wctl.ack_sequence_go)              op_req = OP_ACK;
    else if (wctl.master_receive_go)       op_req = OP_RECV;
    else if (wctl.stop_go)                 op_req = OP_STOP;
    else if (wctl.restart_go)              op_req = OP_RESTART;
    else if (wctl.start_go_or_stretch_enable) op_req = OP_START;
    else                                   op_req = OP_NONE;
  end

  always_comb begin
    ctl_nxt     = ctl_r;
    state_nxt   = state_r;
    op_nxt      = op_r;
    drive_nxt   = drive_r;
    div_nxt     = tick ? 16'h0 : (busy ? div_r + 16'h1 : 16'h0);
    bit_nxt     = bit_r;
    rx_nxt      = rx_r;
    ack_lat_nxt = ack_lat_r;
    master_nxt  = master_r;
    ctl_nxt.received_ack_status = 1'b0;
    if (fire && i_avs_byteenable[0] && i_avs_address == ADDR_MODE
        && !busy) begin
      master_nxt = i_avs_writedata[BIT_MASTER];
    end
    if (seq_wr) begin
      ctl_nxt.general_call_irq_enable = wctl.general_call_irq_enable;
      ctl_nxt.ack_value_to_send       = wctl.ack_value_to_send;
      if (!master_r) begin
        // Slave mode: bit 0 is the stretch enable
        ctl_nxt.start_go_or_stretch_enable =
          wctl.start_go_or_stretch_enable;
      end else if (!busy && op_req != OP_NONE) begin
        // Go bits taken only while idle, never queued
        op_nxt      = op_req;
        state_nxt   = IBSC_PH_A;
        bit_nxt     = 3'h0;
        ack_lat_nxt = wctl.ack_value_to_send;
        drive_nxt   = phase_drive(op_req, IBSC_PH_A,
                                  wctl.ack_value_to_send);
        unique case (op_req)
          OP_ACK:     ctl_nxt.ack_sequence_go = 1'b1;
          OP_RECV:    ctl_nxt.master_receive_go = 1'b1;
          OP_STOP:    ctl_nxt.stop_go = 1'b1;
          OP_RESTART: ctl_nxt.restart_go = 1'b1;
          default:    ctl_nxt.start_go_or_stretch_enable = 1'b1;
        endcase
      end
    end
    // Phase stepping on each phase tick
    if (tick) begin
      unique case (state_r)
        IBSC_PH_A: state_nxt = IBSC_PH_B;
        IBSC_PH_B: begin
          state_nxt = IBSC_PH_C;
          if (op_r == OP_RECV) begin
            rx_nxt = {rx_r[6:0], sda_q};
          end
        end
        IBSC_PH_C: state_nxt = IBSC_PH_D;
        default: begin
          if (op_r == OP_RECV && bit_r != 3'(BYTE_BITS - 1)) begin
            state_nxt = IBSC_PH_A;
            bit_nxt   = bit_r + 3'h1;
          end else begin
            // Sequence over: hardware clears its go bit
            state_nxt = IBSC_IDLE;
            op_nxt    = OP_NONE;
            ctl_nxt.ack_sequence_go            = 1'b0;
            ctl_nxt.master_receive_go          = 1'b0;
            ctl_nxt.stop_go                    = 1'b0;
            ctl_nxt.restart_go                 = 1'b0;
            ctl_nxt.start_go_or_stretch_enable = 1'b0;
          end
        end
      endcase
      if (state_nxt != IBSC_IDLE) begin
        drive_nxt = phase_drive(op_r, state_nxt, ack_lat_r);
      end
    end
    // Slave mode: data released, clock held only while stretching
    if (!master_r) begin
      drive_nxt.sda_low = 1'b0;
      drive_nxt.scl_low = stretch_nxt;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ctl_r     <= SEQ_CTL_RESET;
      state_r   <= IBSC_IDLE;
      op_r      <= OP_NONE;
      drive_r   <= '0;
      div_r     <= 16'h0;
      bit_r     <= 3'h0;
      rx_r      <= 8'h0;
      ack_lat_r <= 1'b0;
      master_r  <= MASTER_RESET;
    end else begin
      ctl_r     <= ctl_nxt;
      state_r   <= state_nxt;
      op_r      <= op_nxt;
      drive_r   <= drive_nxt;
      div_r     <= div_nxt;
      bit_r     <= bit_nxt;
      rx_r      <= rx_nxt;
      ack_lat_r <= ack_lat_nxt;
      master_r  <= master_nxt;
    end
  end

  // Open-drain pins: output level always low, enable pulls
  assign o_scl_o  = 1'b0;
  assign o_sda_o  = 1'b0;
  assign o_scl_oe = drive_r.scl_low;
  assign o_sda_oe = drive_r.sda_low;

  // ----------------------------------------------------------------
  // Slave clock stretching after each ninth falling clock edge
  // ----------------------------------------------------------------
  always_comb begin
    scl_d_nxt   = scl_q;
    sda_d_nxt   = sda_q;
    edges_nxt   = edges_r;
    stretch_nxt = stretch_r;
    if (release_wr) begin
      stretch_nxt = 1'b0;
    end
    if (sda_d_r && !sda_q && scl_q) begin
      edges_nxt = 4'h0;
    end else if (scl_d_r && !scl_q) begin
      if (edges_r == 4'(STRETCH_AT - 1)) begin
        edges_nxt   = 4'h0;
        stretch_nxt = 1'b1; // Set wins over release
      end else begin
        edges_nxt = edges_r + 4'h1;
      end
    end
    if (master_r || !ctl_r.start_go_or_stretch_enable) begin
      stretch_nxt = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      scl_d_r   <= 1'b1;
      sda_d_r   <= 1'b1;
      edges_r   <= 4'h0;
      stretch_r <= 1'b0;
    end else begin
      scl_d_r   <= scl_d_nxt;
      sda_d_r   <= sda_d_nxt;
      edges_r   <= edges_nxt;
      stretch_r <= stretch_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  property p_ack_value;
    (op_r == OP_ACK && state_r == IBSC_PH_B)
      |-> drive_r.sda_low == !ack_lat_r && !drive_r.scl_low;
  endproperty
  a_ack_value: assert property (p_ack_value)
    else $error("ack phase drives wrong data or clock");

  property p_stop_end;
    $fell(ctl_r.stop_go) |-> !drive_r.sda_low && !drive_r.scl_low
                             && state_r == IBSC_IDLE;
  endproperty
  a_stop_end: assert property (p_stop_end)
    else $error("stop ended with a line still held");

  property p_restart_edge;
    (op_r == OP_RESTART && state_r == IBSC_PH_C)
      |-> drive_r.sda_low && !drive_r.scl_low;
  endproperty
  a_restart_edge: assert property (p_restart_edge)
    else $error("repeated start data did not fall under clock high");

  property p_start_go;
    (seq_wr && master_r && !busy && op_req == OP_START)
      |=> op_r == OP_START && state_r == IBSC_PH_A
          && ctl_r.start_go_or_stretch_enable;
  endproperty
  a_start_go: assert property (p_start_go)
    else $error("start request not taken");

  property p_start_edge;
    (op_r == OP_START && state_r == IBSC_PH_B)
      |-> drive_r.sda_low && !drive_r.scl_low;
  endproperty
  a_start_edge: assert property (p_start_edge)
    else $error("start data did not fall under clock high");

  property p_no_stretch;
    (!master_r && !ctl_r.start_go_or_stretch_enable) |=> !stretch_r;
  endproperty
  a_no_stretch: assert property (p_no_stretch)
    else $error("stretch while disabled");

  property p_stretch_pin;
    (!master_r && stretch_r) |-> drive_r.scl_low ##1 drive_r.scl_low
                                 || !stretch_r;
  endproperty
  a_stretch_pin: assert property (p_stretch_pin)
    else $error("stretch not driven on clock line");

  property p_busy_ignore;
    (busy && seq_wr && !tick) |=> op_r == $past(op_r);
  endproperty
  a_busy_ignore: assert property (p_busy_ignore)
    else $error("request taken while busy");

  property p_ack_done;
    (op_r == OP_ACK && state_r == IBSC_PH_D && tick)
      |=> !ctl_r.ack_sequence_go && state_r == IBSC_IDLE;
  endproperty
  a_ack_done: assert property (p_ack_done)
    else $error("ack go bit not cleared at end");

  c_start: cover property (op_r == OP_START && tick
                           && state_r == IBSC_PH_D);
  c_stop:  cover property ($fell(ctl_r.stop_go));
  c_ack:   cover property ($fell(ctl_r.ack_sequence_go));
  c_strch: cover property ($rose(stretch_r));

endmodule

`default_nettype wire

// ===== verification/ibsc_bus_peer.sv
/*
  Far side of the two-wire bus: pull-ups, a byte source for master
  receive, a slave-side frame source and wire condition counters.
  Assumes the design's open-drain enables as its inputs.
*/
`timescale 1ns/1ps
`default_nettype none

module ibsc_bus_peer (
  // Design line enables
  input  wire logic i_scl_oe,
  input  wire logic i_sda_oe,
  // Resolved line levels
  output wire logic o_scl,
  output wire logic o_sda
);
  logic       scl_f     = 1'b0;
  logic       sda_f     = 1'b0;
  logic       rx_arm    = 1'b0;
  logic [7:0] rx_byte   = 8'h00;
  logic [3:0] idx       = 4'h0;
  int         start_cnt = 0;
  int         stop_cnt  = 0;

  // ----------------------------------------------------------------
  // Wired-AND with pull-ups: a released line reads high
  // ----------------------------------------------------------------
  assign o_scl = !(i_scl_oe === 1'b1 || scl_f);
  assign o_sda = !(i_sda_oe === 1'b1 || sda_f ||
                   (rx_arm && !rx_byte[3'd7 - idx[2:0]]));

  // Start and Stop conditions seen on the wire
  always @(negedge o_sda) if (o_scl === 1'b1) start_cnt++;
  always @(posedge o_sda) if (o_scl === 1'b1) stop_cnt++;

  // Next data bit after each clock fall, MSB first
  always @(negedge o_scl) begin
    if (rx_arm) begin
      idx <= idx + 4'h1;
      if (idx == 4'h7) rx_arm <= 1'b0;
    end
  end

  // Load a byte for the design to receive
  task automatic arm(input logic [7:0] b);
    rx_byte = b;
    idx     = 4'h0;
    rx_arm  = 1'b1;
  endtask

  // Foreign master: Start, nine clocks at 125 ns, then SDA let go
  task automatic slave_frame();
    // Keep every line edge off the sampling clock edge
    #1;
    sda_f = 1'b1;
    #125;
    repeat (9) begin
      scl_f = 1'b1;
      #63;
      scl_f = 1'b0;
      #62;
    end
    #125;
    sda_f = 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== verification/tb.sv
/*
  Self-checking bench of the bus sequence control block.
  Assumes the Avalon slave answers after waitrequest drops.
*/
`timescale 1ns/1ps
`default_nettype none

module tb;
  import ibsc_pkg::*;
  logic        clk;
  logic        rst;
  logic [3:0]  addr;
  logic        rd;
  logic        wr;
  logic [31:0] wd;
  logic        tag;
  logic [31:0] rdata;
  logic        wreq;
  logic        scl;
  logic        sda;
  logic        scl_oe;
  logic        sda_oe;
  logic        scl_o;
  logic        sda_o;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  logic [31:0] tmp;
  logic [7:0]  rnd_b;
  logic        ack_watch;
  logic        ack_v;
  integer      seed = 32'h4d5dc41d;
  int          miscompares = 0;
  int          checks_done = 0;
  int          cyc = 0;
  int          s0;
  int          p0;

  ibsc_seq_ctl #(.PHASE_CYC(4)) ibsc_seq_ctl_i (
    .i_clk(clk), .i_reset(rst), .i_avs_address(addr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
    .i_avs_byteenable(4'hf), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wreq), .i_scl(scl), .i_sda(sda),
    .o_scl_o(scl_o), .o_scl_oe(scl_oe), .o_sda_o(sda_o),
    .o_sda_oe(sda_oe));

  ibsc_bus_peer ibsc_bus_peer_i (
    .i_scl_oe(scl_oe), .i_sda_oe(sda_oe), .o_scl(scl), .o_sda(sda));

  // ----------------------------------------------------------------
  // Clock, timeout, checking helpers
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      summarize();
    end
  end

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic summarize();
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Read answers compared against the oldest note
  always @(posedge clk) begin
    if (tag && rd && wreq === 1'b0)
      chk($sformatf("readdata %h", addr), exp_q.pop_front(),
          rdata & msk_q.pop_front());
  end

  // Acknowledge value while SCL is released in the sequence
  always @(posedge clk) begin
    if (ack_watch && scl_oe === 1'b0)
      chk("sda_oe in ack", {31'h0, ~ack_v}, {31'h0, sda_oe});
  end

  // One Avalon transfer; noise in the unused upper bytes
  task automatic bus(input logic [3:0] a, input logic w,
                     input logic [7:0] d, input logic t);
    @(posedge clk);
    addr <= a;
    wr   <= w;
    rd   <= !w;
    tag  <= t;
    wd   <= ($random(seed) & 32'hffffff00) | {24'h0, d};
    // Hold the request until an edge that samples waitrequest low
    do @(posedge clk); while (wreq !== 1'b0);
    tmp = rdata;
    wr  <= 1'b0;
    rd  <= 1'b0;
    tag <= 1'b0;
  endtask

  task automatic rdchk(input logic [3:0] a, input logic [31:0] e,
                       input logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    bus(a, 1'b0, 8'h00, 1'b1);
  endtask

  // Go bits are set only once the block is idle
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      bus(ADDR_STATUS, 1'b0, 8'h00, 1'b0);
      n++;
    end while (tmp[BIT_BUSY] !== 1'b0 && n < 200);
    chk("busy", 32'h0, {31'h0, tmp[BIT_BUSY]});
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    addr = 4'h0;
    rd = 1'b0;
    wr = 1'b0;
    wd = 32'h0;
    tag = 1'b0;
    ack_watch = 1'b0;
    ack_v = 1'b0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rdchk(ADDR_SEQ_CTL, {24'h0, SEQ_CTL_RESET}, 32'hffffffff);
    rdchk(ADDR_MODE, 32'h0, 32'h1);
    rdchk(ADDR_STATUS, 32'h0, 32'h3);
    rdchk(4'hc, 32'h0, 32'hffffffff);
    bus(ADDR_MODE, 1'b1, 8'h01, 1'b0);
    rdchk(ADDR_MODE, 32'h1, 32'h1);
    s0 = ibsc_bus_peer_i.start_cnt;
    p0 = ibsc_bus_peer_i.stop_cnt;
    bus(ADDR_SEQ_CTL, 1'b1, 8'h01, 1'b0);
    bus(ADDR_SEQ_CTL, 1'b1, 8'h04, 1'b0);
    wait_idle();
    rdchk(ADDR_SEQ_CTL, 32'h0, 32'hffffffff);
    chk("starts", s0 + 1, ibsc_bus_peer_i.start_cnt);
    chk("stops", p0, ibsc_bus_peer_i.stop_cnt);
    chk("oe", 32'h3, {30'h0, sda_oe, scl_oe});
    chk("line out level", 32'h0, {30'h0, sda_o, scl_o});
    bus(ADDR_SEQ_CTL, 1'b1, 8'h02, 1'b0);
    wait_idle();
    rdchk(ADDR_SEQ_CTL, 32'h0, 32'hffffffff);
    chk("restarts", s0 + 2, ibsc_bus_peer_i.start_cnt);
    chk("oe", 32'h3, {30'h0, sda_oe, scl_oe});
    rnd_b = 8'($random(seed));
    ibsc_bus_peer_i.arm(rnd_b);
    bus(ADDR_SEQ_CTL, 1'b1, 8'h08, 1'b0);
    wait_idle();
    rdchk(ADDR_STATUS, {16'h0, rnd_b, 8'h00}, 32'h0000ff01);
    for (int v = 0; v < 2; v++) begin
      ack_v = v[0];
      ack_watch = 1'b1;
      bus(ADDR_SEQ_CTL, 1'b1, v[0] ? 8'h30 : 8'h10, 1'b0);
      wait_idle();
      ack_watch = 1'b0;
      rdchk(ADDR_SEQ_CTL, v[0] ? 32'h20 : 32'h0, 32'hff);
    end
    // Stop, with general call enable set and read-only bit 6 written
    bus(ADDR_SEQ_CTL, 1'b1, 8'hc4, 1'b0);
    wait_idle();
    rdchk(ADDR_SEQ_CTL, 32'h80, 32'hff);
    chk("stops", p0 + 1, ibsc_bus_peer_i.stop_cnt);
    chk("oe", 32'h0, {30'h0, sda_oe, scl_oe});
    bus(ADDR_MODE, 1'b1, 8'h00, 1'b0);
    bus(ADDR_SEQ_CTL, 1'b1, 8'h01, 1'b0);
    rdchk(ADDR_SEQ_CTL, 32'h1, 32'hff);
    ibsc_bus_peer_i.slave_frame();
    repeat (20) @(posedge clk);
    rdchk(ADDR_STATUS, 32'h2, 32'h2);
    chk("scl_oe stretch", 32'h1, {31'h0, scl_oe});
    bus(ADDR_MODE, 1'b1, 8'h02, 1'b0);
    repeat (10) @(posedge clk);
    chk("scl_oe release", 32'h0, {31'h0, scl_oe});
    bus(ADDR_SEQ_CTL, 1'b1, 8'h00, 1'b0);
    ibsc_bus_peer_i.slave_frame();
    repeat (20) @(posedge clk);
    chk("scl_oe no stretch", 32'h0, {31'h0, scl_oe});
    rdchk(ADDR_STATUS, 32'h0, 32'h2);
    summarize();
  end
endmodule
`default_nettype wire
